/* File: core/adc_pair_pkg.sv */
// Function
// - when a pair's irq enable bit is set, completion of that pair's conversion sets its status bit, raising irq if its mask bit is set; otherwise none.
// - a pair's pending flag is set when the trigger source selected for that pair is asserted.
// - the pending flag reads one while the pair's conversion is outstanding and returns to zero on completion.
// - writing one to a pair's software trigger bit starts its conversion only when the select chooses the individual software trigger.
// - hardware clears the software trigger bit in the same event that sets the pending flag.
// - bits 12 to 8 select the high pair's trigger source and bits 7 to 0 hold the same layout for the low pair.
// - select codes 0 to 12 are none, individual soft, global soft, pwm special event, pwm 1-8 primary, timer1 period.
// - select codes 13 to 31 are pwm secondary special event, pwm 1-9 secondary, pwm 1-8 current limit, timer2 period.
package adc_pair_pkg;
    localparam logic [3:0]  ctrl_offset    = 4'h0;
    localparam logic [3:0]  irq_stat_offset = 4'h4;
    localparam logic [3:0]  irq_mask_offset = 4'h8;
    localparam logic [15:0] ctrl_reset     = 16'h0000;
    localparam int          hi_base        = 8;
    localparam int          lo_base        = 0;
    localparam int          irq_en_pos     = 7;
    localparam int          pend_pos       = 6;
    localparam int          swtrg_pos      = 5;
    localparam logic [4:0]  sel_none       = 5'h00;
    localparam logic [4:0]  sel_soft       = 5'h01;
    localparam logic [4:0]  sel_global     = 5'h02;
    localparam logic [4:0]  sel_pwm_sevt   = 5'h03;
    localparam logic [4:0]  sel_pwm_pri    = 5'h04;
    localparam logic [4:0]  sel_timer1     = 5'h0c;
    localparam logic [4:0]  sel_pwm_ssevt  = 5'h0d;
    localparam logic [4:0]  sel_pwm_sec    = 5'h0e;
    localparam logic [4:0]  sel_pwm_cl     = 5'h17;
    localparam logic [4:0]  sel_timer2     = 5'h1f;

    typedef struct packed {
        logic [8:0] pwm_cl;
        logic [8:0] pwm_sec;
        logic [7:0] pwm_pri;
        logic       pwm_sevt;
        logic       pwm_ssevt;
        logic       global_soft;
        logic       timer1;
        logic       timer2;
    } trig_src_t;

    typedef struct packed {
        logic       irq_enable;
        logic       pending;
        logic       soft_trigger;
        logic [4:0] trigger_select;
    } pair_ctrl_t;
endpackage

/* File: core/adc_pair_trigger_control.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_pair_trigger_control
    import adc_pair_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire trig_src_t   trig_src,
    input  wire logic [1:0]  conv_done,
    output logic      [1:0]  conv_start,
    output logic             irq
);
    pair_ctrl_t  pair_q [2];
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic        ack_q;
    logic [1:0]  start_ev;
    logic [1:0]  soft_ev;
    logic [1:0]  done_ev;
    logic        acc;
    logic        rd_acc;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_mask;
    logic [31:0] rd_word;

    // a request is taken once; ack_q hides it while waitrequest is low
    assign acc     = (avs_read | avs_write) & ~ack_q;
    assign rd_acc  = acc & avs_read;
    assign wr_ctrl = acc & avs_write & (avs_address == ctrl_offset);
    assign wr_stat = acc & avs_write & (avs_address == irq_stat_offset) & avs_byteenable[0];
    assign wr_mask = acc & avs_write & (avs_address == irq_mask_offset) & avs_byteenable[0];

    // select decode: true when the chosen source fires
    function automatic logic src_hit(
        input logic [4:0] s,
        input trig_src_t  t,
        input logic       sw
    );
        logic h;
        h = 1'h0;
        if (s == sel_soft) begin
            h = sw;
        end else if (s == sel_global) begin
            h = t.global_soft;
        end else if (s == sel_pwm_sevt) begin
            h = t.pwm_sevt;
        end else if (s >= sel_pwm_pri && s < sel_timer1) begin
            h = t.pwm_pri[3'(s - sel_pwm_pri)];
        end else if (s == sel_timer1) begin
            h = t.timer1;
        end else if (s == sel_pwm_ssevt) begin
            h = t.pwm_ssevt;
        end else if (s >= sel_pwm_sec && s < sel_pwm_cl) begin
            h = t.pwm_sec[4'(s - sel_pwm_sec)];
        end else if (s >= sel_pwm_cl && s < sel_timer2) begin
            h = t.pwm_cl[4'(s - sel_pwm_cl)];
        end else if (s == sel_timer2) begin
            h = t.timer2;
        end
        return h;
    endfunction

    generate
        for (genvar i = 0; i < 2; i++) begin : g_pair
            // byte lane i carries pair i: lane 1 the high pair, lane 0 the low pair
            localparam int b       = (i == 1) ? hi_base : lo_base;
            localparam int en_bit  = b + irq_en_pos;
            localparam int pd_bit  = b + pend_pos;
            localparam int sw_bit  = b + swtrg_pos;
            localparam int sel_msb = b + 4;
            logic       byte_wr;
            logic       sw_req;
            logic       src_fire;
            logic       irq_en_q;
            logic       pend_q;
            logic       swtrg_q;
            logic [4:0] sel_q;

            assign byte_wr     = wr_ctrl & avs_byteenable[i];
            assign soft_ev[i]  = byte_wr & avs_writedata[sw_bit];
            assign sw_req      = soft_ev[i] | swtrg_q;
            assign src_fire    = src_hit(sel_q, trig_src, sw_req);
            // idle pair only; a trigger while pending is dropped, except a written soft trigger bit, which stays set
            assign start_ev[i] = ~pend_q & src_fire;
            assign done_ev[i]  = conv_done[i] & pend_q;
            // read-back view of the pair's four fields
            assign pair_q[i]   = '{irq_enable:     irq_en_q,
                                   pending:        pend_q,
                                   soft_trigger:   swtrg_q,
                                   trigger_select: sel_q};

            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    irq_en_q <= ctrl_reset[en_bit];
                end else if (byte_wr) begin
                    irq_en_q <= avs_writedata[en_bit];
                end
            end

            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    sel_q <= ctrl_reset[sel_msb:b];
                end else if (byte_wr) begin
                    sel_q <= avs_writedata[sel_msb:b];
                end
            end

            // a start clears the bit even when it is written in the same cycle
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    swtrg_q <= ctrl_reset[sw_bit];
                end else if (start_ev[i]) begin
                    swtrg_q <= 1'h0;
                end else if (byte_wr) begin
                    swtrg_q <= avs_writedata[sw_bit];
                end
            end

            // read-only to software; a start beats a completion in the same cycle
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    pend_q <= ctrl_reset[pd_bit];
                end else if (start_ev[i]) begin
                    pend_q <= 1'h1;
                end else if (done_ev[i]) begin
                    pend_q <= 1'h0;
                end
            end
        end
    endgenerate

    // start pulse to the converter, one cycle per accepted trigger
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            conv_start <= 2'h0;
        end else begin
            conv_start <= start_ev;
        end
    end

    // sticky completion status, bit 1 the high pair; a completion beats a clear
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            stat_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (done_ev[i] & pair_q[i].irq_enable) begin
                    stat_q[i] <= 1'h1;
                end else if (wr_stat & avs_writedata[i]) begin
                    stat_q[i] <= 1'h0;
                end
            end
        end
    end

    // mask register, same layout as the status register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mask_q <= 2'h0;
        end else if (wr_mask) begin
            mask_q <= avs_writedata[1:0];
        end
    end

    // level interrupt, one cycle behind status and mask
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq <= 1'h0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (avs_address)
            ctrl_offset:     rd_word = {16'h0000, pair_q[1], pair_q[0]};
            irq_stat_offset: rd_word = {30'h0, stat_q};
            irq_mask_offset: rd_word = {30'h0, mask_q};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    // one wait cycle per access: taken at the first edge, answered the cycle after
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ack_q <= 1'h0;
        end else begin
            ack_q <= acc;
        end
    end

    // data captured at the taking edge, stands while waitrequest is low
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            avs_readdata <= rd_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~acc;
        end
    end
endmodule // adc_pair_trigger_control
`default_nettype wire

/* File: verif/adc_pair_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_pair_chk (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic [1:0] conv_start,
    input wire logic [1:0] conv_done,
    input wire logic       irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low twice");
    wait_ans_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("no answer");
    wait_idle_a: assert property (!avs_read && !avs_write && !$past(avs_read || avs_write)
        |-> avs_waitrequest) else $error("spurious answer");
    hi_once_a: assert property (conv_start[1] |=> !conv_start[1])
        else $error("hi start twice");
    lo_once_a: assert property (conv_start[0] |=> !conv_start[0])
        else $error("lo start twice");
    rst_quiet_a: assert property ($rose(resetn) |-> !irq && conv_start == 2'h0)
        else $error("busy after reset");
    irq_rise_a: assert property ($rose(irq) |-> $past(conv_done, 2) != 2'h0
        || $past(avs_write, 2)) else $error("irq without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(avs_write, 2))
        else $error("irq dropped alone");
    cover property (conv_start[1]);
    cover property (conv_start[0]);
    cover property ($rose(irq));
endmodule // adc_pair_chk
bind adc_pair_trigger_control adc_pair_chk u_chk (.core_clk, .resetn, .avs_read, .avs_write,
    .avs_waitrequest, .conv_start, .conv_done, .irq);
`default_nettype wire

/* File: verif/sar_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_core_model #(parameter int lat = 8) (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [1:0] conv_start,
    output logic     [1:0] conv_done
);
    logic [lat-1:0] hi_q, lo_q;
    // each start comes back as one done pulse lat cycles later
    always_ff @(posedge core_clk) begin
        hi_q <= resetn ? {hi_q[lat-2:0], conv_start[1]} : '0;
        lo_q <= resetn ? {lo_q[lat-2:0], conv_start[0]} : '0;
    end
    assign conv_done = {hi_q[lat-1], lo_q[lat-1]};
endmodule // sar_core_model
`default_nettype wire

/* File: verif/tb_adc_pair_trigger_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_pair_trigger_control;
    import adc_pair_pkg::*;
    logic        core_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
    logic [3:0]  avs_address = '0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic [1:0]  conv_start, conv_done;
    trig_src_t   trig_src = '0;
    int          errors = 0, n_compared = 0;
    adc_pair_trigger_control uut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .trig_src,
        .conv_done, .conv_start, .irq);
    sar_core_model sar (.core_clk, .resetn, .conv_start, .conv_done);
    initial forever #2.5 core_clk = ~core_clk;
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    function automatic trig_src_t src(input int c);
        src = '0;
        if (c == 2) src.global_soft = 1;
        if (c == 3) src.pwm_sevt = 1;
        if (c >= 4 && c <= 11) src.pwm_pri[c-4] = 1;
        if (c == 12) src.timer1 = 1;
        if (c == 13) src.pwm_ssevt = 1;
        if (c >= 14 && c <= 22) src.pwm_sec[c-14] = 1;
        if (c >= 23 && c <= 30) src.pwm_cl[c-23] = 1;
        if (c == 31) src.timer2 = 1;
    endfunction
    task pulse(input trig_src_t t);
        @(posedge core_clk);
        trig_src <= t;
        @(posedge core_clk);
        trig_src <= '0;
    endtask
    task reset_check;
        acc(0, 4'h0, 0);
        chk("ctrl", rd, 32'h0);
        acc(0, 4'hc, 0);
        chk("unmapped", rd, 32'h0);
    endtask
    task soft_start;
        acc(1, 4'h8, 32'h3);
        acc(1, 4'h0, 32'h2000);
        acc(0, 4'h0, 0);
        chk("soft_idle", rd, 32'h2000);
        acc(1, 4'h0, 32'ha100);
        acc(0, 4'h0, 0);
        chk("pend", rd, 32'hc100);
        repeat (14) @(posedge core_clk);
        acc(0, 4'h0, 0);
        chk("done", rd, 32'h8100);
        chk("irq", irq, 1);
        acc(1, 4'h4, 32'h3);
        repeat (2) @(posedge core_clk);
        chk("irq_clr", irq, 0);
    endtask
    task codes;
        for (int c = 0; c < 32; c++) begin
            acc(1, 4'h0, c);
            pulse(~src(c));
            acc(0, 4'h0, 0);
            chk("other", rd, c);
            pulse(src(c));
            acc(0, 4'h0, 0);
            chk("sel", rd, c | (c > 1 ? 32'h40 : 0));
            repeat (12) @(posedge core_clk);
        end
        chk("irq_off", irq, 0);
    endtask
    task complete_run;
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1;
        reset_check;
        soft_start;
        codes;
        complete_run;
    end
    initial begin
        #20us;
        errors++;
        complete_run;
    end
endmodule // tb_adc_pair_trigger_control
`default_nettype wire
